// file: include/fault_mask_pkg.sv
/*
 * constants shared by the fault interrupt mask block: register addresses,
 * mask bit positions, reset values and the three overcurrent indicator addresses.
 * assumes an 8-bit register port with an 8-bit address from the i2c front end.
 */
package fault_mask_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 3;

    localparam logic [7:0] THERMAL_SUPPLY_IRQ_MASK_ADDR = 8'h32;
    localparam logic [7:0] CHANNEL1_IRQ_MASK_ADDR = 8'h33;
    localparam logic [7:0] CHANNEL2_IRQ_MASK_ADDR = 8'h34;
    localparam logic [7:0] CHANNEL3_IRQ_MASK_ADDR = 8'h35;
    // overcurrent indicator record registers, one per channel
    localparam logic [7:0] CH1_RECORD_ADDR = 8'h14;
    localparam logic [7:0] CH2_RECORD_ADDR = 8'h15;
    localparam logic [7:0] CH3_RECORD_ADDR = 8'h16;

    localparam int LOCKOUT_BIT = 7;
    localparam int HOT_DIE_BIT = 2;
    localparam int THERMAL_SHUTDOWN_BIT = 1;
    localparam int POWER_GOOD_BIT = 7;
    localparam int OVERCURRENT_BIT = 6;
    localparam int OVERVOLTAGE_BIT = 5;
    localparam int UNDERVOLTAGE_BIT = 4;

    localparam logic [7:0] THERMAL_MASK_WRITABLE = 8'h86;
    localparam logic [7:0] CHANNEL_MASK_WRITABLE = 8'hf0;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] DATA_ZERO = 8'h00;

endpackage

// file: rtl/fault_interrupt_mask.sv
/*
 * interrupt masking of the regulator fault detections: four mask registers
 * written by the i2c register port, per-channel read-clear overcurrent
 * indicators, and one registered interrupt request.
 * assumes the register port and detectors run on clk; pin polarity and drive
 * are handled outside this block.
 */
// What this block does
// RULE1: mask bit 7 of the thermal and supply register blocks the supply lockout source when 1.
// RULE2: mask bit 2 of the thermal and supply register blocks the hot die source when 1.
// RULE3: mask bit 1 of the thermal and supply register blocks thermal shutdown when 1.
// RULE4: bit 7 of the channel 1 mask blocks channel 1 power good when 1.
// RULE5: bit 6 of the channel 1 mask blocks channel 1 overcurrent when 1.
// RULE6: bit 5 of the channel 1 mask blocks channel 1 overvoltage when 1.
// RULE7: bit 4 of the channel 1 mask blocks channel 1 undervoltage when 1.
// RULE8: channel 2 mask bits 7..4 block power good, overcurrent, overvoltage, undervoltage.
// RULE9: channel 3 mask bits 7..4 block power good, overcurrent, overvoltage, undervoltage.
// RULE10: overcurrent indicators are read-only and clear when the host reads them.
// RULE11: the interrupt request is the OR of every source whose mask bit is 0.
// RULE12: reserved mask bits read zero and ignore writes, and all masks reset to 0.
`timescale 1ns/1ps
module fault_interrupt_mask #(
    parameter int NUM_CH = fault_mask_pkg::NUM_CH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic lockout_det,
    input wire logic hot_die_det,
    input wire logic thermal_shutdown_det,
    input wire logic [NUM_CH-1:0] power_good_det,
    input wire logic [NUM_CH-1:0] overcurrent_det,
    input wire logic [NUM_CH-1:0] overvoltage_det,
    input wire logic [NUM_CH-1:0] undervoltage_det,
    output logic irq
);
    // the address decode below serves exactly three channels
    if (NUM_CH != 3) begin : g_bad_num_ch
        $error("fault_interrupt_mask supports exactly three channels");
    end

    typedef struct packed {
        logic [7:0] thermal_mask;
        logic [NUM_CH-1:0][7:0] ch_mask;
        logic [7:0] rdata;
        logic irq;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [NUM_CH-1:0] oc_flag;
    logic [NUM_CH-1:0] oc_rd_clr;

    ////////////////////////////////////////////////////////////////////////
    // address decode shared by write, read and read-clear
    function automatic logic [7:0] ch_mask_addr(input int ch);
        case (ch)
            0: ch_mask_addr = fault_mask_pkg::CHANNEL1_IRQ_MASK_ADDR;
            1: ch_mask_addr = fault_mask_pkg::CHANNEL2_IRQ_MASK_ADDR;
            default: ch_mask_addr = fault_mask_pkg::CHANNEL3_IRQ_MASK_ADDR;
        endcase
    endfunction

    function automatic logic [7:0] ch_record_addr(input int ch);
        case (ch)
            0: ch_record_addr = fault_mask_pkg::CH1_RECORD_ADDR;
            1: ch_record_addr = fault_mask_pkg::CH2_RECORD_ADDR;
            default: ch_record_addr = fault_mask_pkg::CH3_RECORD_ADDR;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // read-clear overcurrent indicators
    for (genvar c = 0; c < NUM_CH; c++) begin : g_oc
        assign oc_rd_clr[c] = reg_rd && (reg_addr == ch_record_addr(c)); // RULE10
        oc_sticky_flag u_flag (
            .clk(clk),
            .rst_n(rst_n),
            .det(overcurrent_det[c]),
            .rd_clr(oc_rd_clr[c]),
            .flag(oc_flag[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic any;
        any = 1'b0;
        s_d = s_q;

        // only documented mask fields take a write
        if (reg_wr && reg_addr == fault_mask_pkg::THERMAL_SUPPLY_IRQ_MASK_ADDR) begin
            s_d.thermal_mask = reg_wdata & fault_mask_pkg::THERMAL_MASK_WRITABLE; // RULE12
        end
        for (int c = 0; c < NUM_CH; c++) begin
            if (reg_wr && reg_addr == ch_mask_addr(c)) begin
                s_d.ch_mask[c] = reg_wdata & fault_mask_pkg::CHANNEL_MASK_WRITABLE; // RULE12
            end
        end

        // read data registered one cycle after the read strobe
        s_d.rdata = fault_mask_pkg::DATA_ZERO;
        if (reg_rd) begin
            if (reg_addr == fault_mask_pkg::THERMAL_SUPPLY_IRQ_MASK_ADDR) begin
                s_d.rdata = s_q.thermal_mask;
            end
            for (int c = 0; c < NUM_CH; c++) begin
                if (reg_addr == ch_mask_addr(c)) begin
                    s_d.rdata = s_q.ch_mask[c];
                end
                if (reg_addr == ch_record_addr(c)) begin
                    // power good, oc flag, ov and uv levels; low nibble reserved
                    s_d.rdata = {power_good_det[c], oc_flag[c], overvoltage_det[c],
                                 undervoltage_det[c], 4'h0}; // RULE10
                end
            end
        end

        any = lockout_det & ~s_q.thermal_mask[fault_mask_pkg::LOCKOUT_BIT]; // RULE1
        any = any | (hot_die_det & ~s_q.thermal_mask[fault_mask_pkg::HOT_DIE_BIT]); // RULE2
        any = any | (thermal_shutdown_det
                     & ~s_q.thermal_mask[fault_mask_pkg::THERMAL_SHUTDOWN_BIT]); // RULE3
        // channel index 0 is channel 1, 1 is channel 2, 2 is channel 3
        for (int c = 0; c < NUM_CH; c++) begin
            any = any | (power_good_det[c]
                         & ~s_q.ch_mask[c][fault_mask_pkg::POWER_GOOD_BIT]); // RULE4 RULE8 RULE9
            any = any | (oc_flag[c]
                         & ~s_q.ch_mask[c][fault_mask_pkg::OVERCURRENT_BIT]); // RULE5 RULE8 RULE9
            any = any | (overvoltage_det[c]
                         & ~s_q.ch_mask[c][fault_mask_pkg::OVERVOLTAGE_BIT]); // RULE6 RULE8 RULE9
            any = any | (undervoltage_det[c]
                         & ~s_q.ch_mask[c][fault_mask_pkg::UNDERVOLTAGE_BIT]); // RULE7 RULE8 RULE9
        end
        s_d.irq = any; // RULE11
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q.thermal_mask <= fault_mask_pkg::MASK_RESET; // RULE12
            s_q.ch_mask <= {NUM_CH{fault_mask_pkg::MASK_RESET}}; // RULE12
            s_q.rdata <= fault_mask_pkg::DATA_ZERO;
            s_q.irq <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign irq = s_q.irq;
endmodule

// file: rtl/oc_sticky_flag.sv
/*
 * one sticky overcurrent indicator: set by the detector, cleared when read.
 * assumes det comes from logic on clk and rd_clr is a one-cycle pulse.
 */
`timescale 1ns/1ps
module oc_sticky_flag (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic det,
    input wire logic rd_clr,
    output logic flag
);
    typedef struct packed {
        logic flag;
    } state_t;

    state_t s_q;
    state_t s_d;

    always_comb begin
        s_d = s_q;
        // a new event in the clearing cycle survives the read
        s_d.flag = det | (s_q.flag & ~rd_clr); // RULE10
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flag = s_q.flag;
endmodule

// file: verification/fault_interrupt_mask_assertions.sv
/* checker for the fault interrupt mask block.
   sees only the block ports; bound from the testbench top file. */
`timescale 1ns/1ps
module fault_interrupt_mask_assertions #(
    parameter int NUM_CH = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic lockout_det,
    input wire logic hot_die_det,
    input wire logic thermal_shutdown_det,
    input wire logic [NUM_CH-1:0] power_good_det,
    input wire logic [NUM_CH-1:0] overcurrent_det,
    input wire logic [NUM_CH-1:0] overvoltage_det,
    input wire logic [NUM_CH-1:0] undervoltage_det,
    input wire logic irq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic any_det;
    assign any_det = lockout_det | hot_die_det | thermal_shutdown_det | (|power_good_det)
        | (|overcurrent_det) | (|overvoltage_det) | (|undervoltage_det);
    property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data not zero when idle");
    property p_unmap; reg_rd && !(reg_addr inside {[8'h14:8'h16], [8'h32:8'h35]})
        |=> reg_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rsv_t; reg_rd && reg_addr == 8'h32 |=> (reg_rdata & 8'h79) == 8'h00; endproperty
    a_rsv_t: assert property (p_rsv_t) else $error("thermal reserved bits set");
    property p_rsv_c; reg_rd && reg_addr inside {[8'h33:8'h35]} |=> reg_rdata[3:0] == 4'h0;
    endproperty
    a_rsv_c: assert property (p_rsv_c) else $error("channel reserved bits set");
    property p_wr_rd; reg_wr && reg_addr == 8'h32 ##1 !reg_wr ##1 reg_rd && !reg_wr
        && reg_addr == 8'h32 |=> reg_rdata == ($past(reg_wdata, 3) & 8'h86); endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("thermal mask readback wrong");
    property p_cause; $rose(irq) |-> $past(any_det) || $past(any_det, 2); endproperty
    a_cause: assert property (p_cause) else $error("irq rose with no detection");
    property p_oc_clr; reg_rd && reg_addr == 8'h14 && !overcurrent_det[0] ##1 !overcurrent_det[0]
        ##1 reg_rd && reg_addr == 8'h14 && !overcurrent_det[0] |=> !reg_rdata[6]; endproperty
    a_oc_clr: assert property (p_oc_clr) else $error("overcurrent flag not cleared");
    property p_oc_set; reg_rd && reg_addr == 8'h14 && $past(overcurrent_det[0]) && $past(rst_n)
        |=> reg_rdata[6]; endproperty
    a_oc_set: assert property (p_oc_set) else $error("overcurrent flag lost");
    cover property (reg_wr && reg_addr == 8'h33);
    cover property ($rose(irq));
    cover property ($fell(irq));
endmodule

// file: verification/fault_interrupt_mask_test.sv
/* top testbench: corner cases, then random masks and detections (seed 50).
   host_model drives the register port; detectors are driven here. */
`timescale 1ns/1ps
module fault_interrupt_mask_test;
    logic clk = 0, rst_n = 0, reg_wr, reg_rd, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
    logic lockout_det = 0, hot_die_det = 0, thermal_shutdown_det = 0;
    logic [2:0] power_good_det = 0, overcurrent_det = 0, overvoltage_det = 0;
    logic [2:0] undervoltage_det = 0, sticky = 0;
    logic [7:0] m [4];
    logic [7:0] wmask [4] = '{8'h86, 8'hf0, 8'hf0, 8'hf0};
    int err_count = 0, n_compared = 0;
    fault_interrupt_mask i_dut (.*);
    host_model i_host (.*);
    always #2.5 clk = ~clk;
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    function automatic logic f_irq();
        f_irq = |({lockout_det, hot_die_det, thermal_shutdown_det} & ~{m[0][7], m[0][2], m[0][1]});
        for (int c = 0; c < 3; c++) begin
            f_irq |= |({power_good_det[c], sticky[c], overvoltage_det[c], undervoltage_det[c]}
                & ~m[c + 1][7:4]);
        end
    endfunction
    initial begin
        q = 8'($urandom(50));
        repeat (4) @(negedge clk);
        rst_n = 1;
        for (int a = 0; a < 4; a++) begin
            i_host.rd(8'h32 + 8'(a), q);
            chk(q, 8'h00);
        end
        i_host.wr(8'h32, 8'hff);
        i_host.rd(8'h32, q);
        chk(q, 8'h86);
        i_host.wr(8'h40, 8'hff);
        i_host.rd(8'h40, q);
        chk(q, 8'h00);
        i_host.rd(8'h14, q);
        i_host.rd(8'h14, q);
        chk(q, 8'h00);
        $display("test registers done");
        // first pass masks everything with every source active: irq must stay low
        for (int i = 0; i < 300; i++) begin
            for (int a = 0; a < 4; a++) begin
                m[a] = (i == 0) ? wmask[a] : 8'($urandom | $urandom) & wmask[a];
                i_host.wr(8'h32 + 8'(a), m[a] | ~wmask[a]);
            end
            @(negedge clk);
            {lockout_det, hot_die_det, thermal_shutdown_det} = (i == 0) ? 3'h7 : 3'($urandom);
            {power_good_det, overcurrent_det, overvoltage_det, undervoltage_det} =
                (i == 0) ? 12'hfff : 12'($urandom & $urandom);
            sticky |= overcurrent_det;
            repeat (3) @(negedge clk);
            chk({7'h0, irq}, {7'h0, f_irq()});
            for (int a = 0; a < 4; a++) begin
                i_host.rd(8'h32 + 8'(a), q);
                chk(q, m[a]);
            end
            for (int c = 0; c < 3; c++) begin
                i_host.rd(8'h14 + 8'(c), q);
                chk(q, {power_good_det[c], sticky[c], overvoltage_det[c], undervoltage_det[c], 4'h0});
                sticky[c] = overcurrent_det[c];
            end
        end
        $display("test random done");
        end_of_test();
    end
    initial begin
        #200000;
        err_count++;
        end_of_test();
    end
endmodule
bind fault_interrupt_mask fault_interrupt_mask_assertions #(.NUM_CH(NUM_CH)) i_chk (.*);

// file: verification/host_model.sv
/* host processor model: byte writes and reads on the register port.
   assumes rising-edge sampling in the design; drives at falling edges. */
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr = 0;
        reg_rd = 0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // idle address and data are inverted so nothing leans on stale values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(negedge clk);
        reg_rd = 1;
        reg_addr = a;
        @(negedge clk);
        q = reg_rdata;
        reg_rd = 0;
        reg_addr = ~a;
    endtask
endmodule
